// file: wdit_params.svh
// Constants for the watchdog / interval timer: register offsets, fields, reset values.
// Assumes inclusion by bare name from the prescaler, the timer and the bench.
`ifndef WDIT_PARAMS_SVH
`define WDIT_PARAMS_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define WDIT_OFS_CTRL 12'h000
`define WDIT_OFS_CMD 12'h004
`define WDIT_OFS_COUNT 12'h008
`define WDIT_OFS_STATUS 12'h00c
`define WDIT_OFS_CLEAR 12'h010
`define WDIT_OFS_IRQ_EN 12'h014
`define WDIT_OFS_PRIO 12'h018

// ****************************************
// Control fields
// ****************************************
`define WDIT_CTRL_MODE_BIT 0
`define WDIT_CTRL_ENABLE_BIT 1
`define WDIT_CTRL_RST_EN_BIT 2
`define WDIT_CTRL_RST_SEL_BIT 3
`define WDIT_CTRL_CLKSEL_LSB 4
`define WDIT_CTRL_CLKSEL_MSB 6
`define WDIT_CTRL_RESET 32'h0000_0000

// ****************************************
// Command fields
// ****************************************
`define WDIT_CMD_START_BIT 0
`define WDIT_CMD_STOP_BIT 1
`define WDIT_CMD_CLEAR_BIT 2

// ****************************************
// Status fields
// ****************************************
`define WDIT_ST_ITV_BIT 0
`define WDIT_ST_WDT_BIT 1

// ****************************************
// Prescaler terminal counts (divisor minus one)
// ****************************************
`define WDIT_DIV_64 16'h003f
`define WDIT_DIV_128 16'h007f
`define WDIT_DIV_256 16'h00ff
`define WDIT_DIV_512 16'h01ff
`define WDIT_DIV_1024 16'h03ff
`define WDIT_DIV_4096 16'h0fff
`define WDIT_DIV_16384 16'h3fff

// Reset request pulse width in clocks
`define WDIT_RST_PULSE 4'h4

`endif

// file: wdit_pkg.sv
// Types shared by the watchdog / interval timer files.
// Assumes wdit_params.svh for numeric constants.
package wdit_pkg;

  typedef enum logic [2:0] {
    WDIT_CLK_DIV1 = 3'b000,
    WDIT_CLK_DIV64 = 3'b001,
    WDIT_CLK_DIV128 = 3'b010,
    WDIT_CLK_DIV256 = 3'b011,
    WDIT_CLK_DIV512 = 3'b100,
    WDIT_CLK_DIV1024 = 3'b101,
    WDIT_CLK_DIV4096 = 3'b110,
    WDIT_CLK_DIV16384 = 3'b111
  } wdit_clksel_t;

  typedef enum logic [1:0] {
    WDIT_AX_IDLE = 2'b00,
    WDIT_AX_RESP = 2'b01
  } wdit_ax_t;

endpackage : wdit_pkg

// file: wdit_prescaler.sv
// Prescaler: issues a one-cycle tick at the selected division of the clock.
// Assumes a running aclk; restart clears the phase so a fresh start counts a full period.
`timescale 1ns/100ps
`include "wdit_params.svh"
module wdit_prescaler
  import wdit_pkg::*;
#(
  parameter int WIDTH = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire wdit_clksel_t sel,
  output logic tick
);

  typedef struct packed {
    logic [WIDTH-1:0] cnt;
  } wdit_pre_state_t;

  wdit_pre_state_t s;
  wdit_pre_state_t next_s;
  logic [WIDTH-1:0] limit;

  always_comb begin
    case (sel)
      WDIT_CLK_DIV64: limit = WIDTH'(`WDIT_DIV_64);
      WDIT_CLK_DIV128: limit = WIDTH'(`WDIT_DIV_128);
      WDIT_CLK_DIV256: limit = WIDTH'(`WDIT_DIV_256);
      WDIT_CLK_DIV512: limit = WIDTH'(`WDIT_DIV_512);
      WDIT_CLK_DIV1024: limit = WIDTH'(`WDIT_DIV_1024);
      WDIT_CLK_DIV4096: limit = WIDTH'(`WDIT_DIV_4096);
      WDIT_CLK_DIV16384: limit = WIDTH'(`WDIT_DIV_16384);
      default: limit = '0;
    endcase
  end

  always_comb begin
    next_s = s;
    tick = 1'b0;
    if (!run) begin
      next_s.cnt = '0;
    end else if (s.cnt >= limit) begin
      next_s.cnt = '0;
      tick = 1'b1;
    end else begin
      next_s.cnt = s.cnt + WIDTH'(1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule : wdit_prescaler

// file: wdit_timer.sv
// Watchdog / interval timer with an AXI4-Lite register slave.
// Assumes one clock aclk and a synchronous active-low reset; reset requests go to a system reset unit.
//
// Overview of operation
// - The timer runs either as an interval timer or as a watchdog, interval mode after reset.
// - The count clock is the plain clock or the clock divided by 64 to 16384, plain clock after reset.
// - A control bit decides whether a watchdog overflow requests a reset, off after reset.
// - A second bit picks a power-on or a manual reset request, power-on after reset.
// - Software may load the counter with a starting value from which it counts to overflow.
// - An overall enable, off after reset, gates the timer; commands start, stop or clear it.
// - Status bit 0 flags an interval overflow and bit 1 a watchdog overflow.
// - Each overflow flag stays set until software clears it, and a new overflow beats the clear.
// - Overflows raise one interrupt request whose priority is a four-bit setting.
// - Disabling the unit stops the counter so no overflow or reset request follows.
//
// Added by the designer: the register offsets and register access over AXI4-Lite.
`timescale 1ns/100ps
`include "wdit_params.svh"
module wdit_timer
  import wdit_pkg::*;
#(
  parameter int CNT_W = 8,
  parameter int PRIO_W = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq,
  output logic [PRIO_W-1:0] irq_priority,
  output logic poweron_reset_req,
  output logic manual_reset_req
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    wdit_ax_t wr_st;
    logic aw_got;
    logic w_got;
    logic [11:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bresp_err;
    wdit_ax_t rd_st;
    logic [31:0] rdata;
    logic rresp_err;
    logic mode_wdt;
    logic enable;
    logic rst_en;
    logic rst_manual;
    wdit_clksel_t clksel;
    logic running;
    logic [CNT_W-1:0] watchdog_count_value;
    logic [1:0] status;
    logic [1:0] irq_en;
    logic [PRIO_W-1:0] prio;
    logic [3:0] rst_cnt;
    logic rst_kind_manual;
  } wdit_state_t;

  wdit_state_t s;
  wdit_state_t next_s;
  logic tick;
  logic wr_fire;
  logic rd_fire;
  logic overflow;
  logic count_step;
  logic rst_busy;

  // Control word as software reads it; the byte merge of a write starts from the same layout
  function automatic logic [31:0] ctrl_word(input wdit_state_t st);
    return {25'h0, st.clksel, st.rst_manual, st.rst_en, st.enable, st.mode_wdt};
  endfunction : ctrl_word

  function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge_bytes

  function automatic logic addr_known(input logic [11:0] a);
    logic k;
    k = 1'b0;
    if (a == `WDIT_OFS_CTRL) begin
      k = 1'b1;
    end else if (a == `WDIT_OFS_CMD) begin
      k = 1'b1;
    end else if (a == `WDIT_OFS_COUNT) begin
      k = 1'b1;
    end else if (a == `WDIT_OFS_STATUS) begin
      k = 1'b1;
    end else if (a == `WDIT_OFS_CLEAR) begin
      k = 1'b1;
    end else if (a == `WDIT_OFS_IRQ_EN) begin
      k = 1'b1;
    end else if (a == `WDIT_OFS_PRIO) begin
      k = 1'b1;
    end
    return k;
  endfunction : addr_known

  // Restarted on every start so the first counted period is a whole one
  wdit_prescaler #(
    .WIDTH(16)
  ) wdit_prescaler_inst (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(s.enable && s.running),
    .sel(s.clksel),
    .tick(tick)
  );

  // ****************************************
  // Bus handshakes
  // ****************************************
  assign s_axi_awready = (s.wr_st == WDIT_AX_IDLE) && !s.aw_got;
  assign s_axi_wready = (s.wr_st == WDIT_AX_IDLE) && !s.w_got;
  assign s_axi_bvalid = (s.wr_st == WDIT_AX_RESP);
  assign s_axi_bresp = s.bresp_err ? 2'b10 : 2'b00;
  // One read at a time: a new address waits until the answer has been taken
  assign s_axi_arready = (s.rd_st == WDIT_AX_IDLE);
  assign s_axi_rvalid = (s.rd_st == WDIT_AX_RESP);
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp_err ? 2'b10 : 2'b00;
  // Address and data arrive in either order; the write lands once both are in hand
  assign wr_fire = (s.wr_st == WDIT_AX_IDLE) && (s.aw_got || s_axi_awvalid) && (s.w_got || s_axi_wvalid);
  assign rd_fire = s_axi_arvalid && s_axi_arready;

  // ****************************************
  // Counter
  // ****************************************
  assign count_step = s.enable && s.running && tick;
  // Overflow only while enabled and started, so a disabled unit is silent
  assign overflow = count_step && (s.watchdog_count_value == '1);

  // ****************************************
  // Outputs
  // ****************************************
  assign irq = |(s.status & s.irq_en);
  assign irq_priority = s.prio;
  // Held for a fixed number of clocks so a slow reset unit still catches it
  assign rst_busy = (s.rst_cnt != 4'h0);
  assign poweron_reset_req = rst_busy && !s.rst_kind_manual;
  assign manual_reset_req = rst_busy && s.rst_kind_manual;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic [11:0] wa;
    logic [31:0] wd;
    logic [3:0] ws;
    logic [31:0] cv;
    logic [1:0] set_flags;
    logic [1:0] clr_flags;
    wa = s.aw_got ? s.awaddr : s_axi_awaddr;
    wd = s.w_got ? s.wdata : s_axi_wdata;
    ws = s.w_got ? s.wstrb : s_axi_wstrb;
    cv = '0;
    set_flags = 2'b00;
    clr_flags = 2'b00;
    next_s = s;

    // Write channel capture, either order
    // Each channel is latched on its own so the master may offer them apart
    if (s.wr_st == WDIT_AX_IDLE) begin
      if (s_axi_awvalid && !s.aw_got) begin
        next_s.aw_got = 1'b1;
        next_s.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !s.w_got) begin
        next_s.w_got = 1'b1;
        next_s.wdata = s_axi_wdata;
        next_s.wstrb = s_axi_wstrb;
      end
    end else if (s_axi_bready) begin
      next_s.wr_st = WDIT_AX_IDLE;
    end

    // Counter advance
    if (count_step) begin
      next_s.watchdog_count_value = s.watchdog_count_value + CNT_W'(1);
    end
    if (overflow) begin
      if (s.mode_wdt) begin
        set_flags[`WDIT_ST_WDT_BIT] = 1'b1;
        if (s.rst_en) begin
          next_s.rst_cnt = `WDIT_RST_PULSE;
          next_s.rst_kind_manual = s.rst_manual;
        end
      end else begin
        set_flags[`WDIT_ST_ITV_BIT] = 1'b1;
      end
    end
    // A fresh watchdog overflow reloads the pulse instead of counting it down
    if (rst_busy && !(overflow && s.mode_wdt && s.rst_en)) begin
      next_s.rst_cnt = s.rst_cnt - 4'h1;
    end

    if (wr_fire) begin
      next_s.wr_st = WDIT_AX_RESP;
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      next_s.bresp_err = !addr_known(wa);
      if (wa == `WDIT_OFS_CTRL) begin
        cv = merge_bytes(ctrl_word(s), wd, ws);
        next_s.mode_wdt = cv[`WDIT_CTRL_MODE_BIT];
        next_s.enable = cv[`WDIT_CTRL_ENABLE_BIT];
        next_s.rst_en = cv[`WDIT_CTRL_RST_EN_BIT];
        next_s.rst_manual = cv[`WDIT_CTRL_RST_SEL_BIT];
        next_s.clksel = wdit_clksel_t'(cv[`WDIT_CTRL_CLKSEL_MSB:`WDIT_CTRL_CLKSEL_LSB]);
        if (!cv[`WDIT_CTRL_ENABLE_BIT]) begin
          next_s.running = 1'b0;
          next_s.rst_cnt = 4'h0;
        end
      end else if (wa == `WDIT_OFS_CMD) begin
        if (ws[0] && wd[`WDIT_CMD_START_BIT] && s.enable) begin
          next_s.running = 1'b1;
        end
        // Stop is applied after start so it wins when both bits are set
        if (ws[0] && wd[`WDIT_CMD_STOP_BIT]) begin
          next_s.running = 1'b0;
        end
        if (ws[0] && wd[`WDIT_CMD_CLEAR_BIT]) begin
          next_s.watchdog_count_value = '0;
        end
      end else if (wa == `WDIT_OFS_COUNT) begin
        // A load in the same cycle as a tick wins, so software reads back what it wrote
        if (ws[0]) begin
          next_s.watchdog_count_value = wd[CNT_W-1:0];
        end
      end else if (wa == `WDIT_OFS_CLEAR) begin
        if (ws[0]) begin
          clr_flags = wd[1:0];
        end
      end else if (wa == `WDIT_OFS_IRQ_EN) begin
        if (ws[0]) begin
          next_s.irq_en = wd[1:0];
        end
      end else if (wa == `WDIT_OFS_PRIO) begin
        if (ws[0]) begin
          next_s.prio = wd[PRIO_W-1:0];
        end
      end
    end

    // Set wins over clear so an overflow in the clearing cycle is kept
    next_s.status = (s.status & ~clr_flags) | set_flags;

    // Read channel
    if (rd_fire) begin
      next_s.rd_st = WDIT_AX_RESP;
      next_s.rresp_err = !addr_known(s_axi_araddr);
      if (s_axi_araddr == `WDIT_OFS_CTRL) begin
        next_s.rdata = ctrl_word(s);
      end else if (s_axi_araddr == `WDIT_OFS_COUNT) begin
        next_s.rdata = {{(32-CNT_W){1'b0}}, s.watchdog_count_value};
      end else if (s_axi_araddr == `WDIT_OFS_STATUS) begin
        next_s.rdata = {29'h0, s.running, s.status};
      end else if (s_axi_araddr == `WDIT_OFS_IRQ_EN) begin
        next_s.rdata = {30'h0, s.irq_en};
      end else if (s_axi_araddr == `WDIT_OFS_PRIO) begin
        next_s.rdata = {{(32-PRIO_W){1'b0}}, s.prio};
      end else begin
        // Write-only and unmapped offsets read as zero
        next_s.rdata = 32'h0000_0000;
      end
    end else if (s.rd_st == WDIT_AX_RESP && s_axi_rready) begin
      next_s.rd_st = WDIT_AX_IDLE;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule : wdit_timer

// file: wdit_timer_sva.sv
// Port checker for the watchdog / interval timer.
// Assumes the bind at the foot attaches it to every wdit_timer.
`timescale 1ns/100ps
module wdit_timer_sva #(
  parameter int CNT_W = 8,
  parameter int PRIO_W = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic irq,
  input wire logic [PRIO_W-1:0] irq_priority,
  input wire logic poweron_reset_req,
  input wire logic manual_reset_req
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ****************
  // Assertions
  // ****************
  property p_quiet; $rose(aresetn) |-> !irq && !poweron_reset_req && !manual_reset_req && irq_priority == '0;
  endproperty
  a_quiet: assert property (p_quiet) else $error("outputs not idle after reset");
  property p_por; $rose(poweron_reset_req) |-> poweron_reset_req[*4] ##1 !poweron_reset_req; endproperty
  a_por: assert property (p_por) else $error("power-on request width");
  property p_man; $rose(manual_reset_req) |-> manual_reset_req[*4] ##1 !manual_reset_req; endproperty
  a_man: assert property (p_man) else $error("manual request width");
  property p_excl; !(poweron_reset_req && manual_reset_req); endproperty
  a_excl: assert property (p_excl) else $error("both reset kinds requested");
  // Priority moves and the interrupt drops only by register writes, which land with the response
  property p_prio; $changed(irq_priority) |-> $rose(s_axi_bvalid); endproperty
  a_prio: assert property (p_prio) else $error("priority changed without write");
  property p_sticky; $fell(irq) |-> $rose(s_axi_bvalid); endproperty
  a_sticky: assert property (p_sticky) else $error("interrupt dropped without write");
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_bhold: assert property (p_bhold) else $error("write response not held");
  property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_rhold: assert property (p_rhold) else $error("read response not held");
  property p_rans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
  a_rans: assert property (p_rans) else $error("read answer late");
endmodule : wdit_timer_sva

bind wdit_timer wdit_timer_sva #(.CNT_W(CNT_W), .PRIO_W(PRIO_W)) wdit_timer_sva_inst (
  .aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .irq(irq),
  .irq_priority(irq_priority), .poweron_reset_req(poweron_reset_req), .manual_reset_req(manual_reset_req));

// file: tb_top.sv
// Self-checking bench for the watchdog / interval timer.
// Assumes wdit_timer and its checker are compiled first.
`timescale 1ns/100ps
`include "wdit_params.svh"
module tb_top;
  logic aclk = 0;
  logic aresetn = 0;
  logic [11:0] awaddr = 0;
  logic [11:0] araddr = 0;
  logic [31:0] wdata = 0;
  logic awvalid = 0;
  logic wvalid = 0;
  logic bready = 0;
  logic arvalid = 0;
  logic rready = 0;
  logic awready, wready, bvalid, arready, rvalid, irq, por, man;
  logic [1:0] bresp, rresp, lb, lr;
  logic [31:0] rdata;
  logic [3:0] prio;
  int errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  int pc, mc, n;
  always #50 aclk = ~aclk;
  wdit_timer wdit_timer_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .irq(irq), .irq_priority(prio), .poweron_reset_req(por), .manual_reset_req(man));
  // ****************
  // Bus tasks
  // ****************
  always @(negedge aclk) begin
    pc += por;
    mc += man;
  end
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  // Handshakes are judged at the rising edge; ready is raised once the answer shows,
  // so the slave must hold it for a cycle
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic done;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    done = 1'b0;
    while (!done) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        lb = bresp;
        bready <= 1'b0;
        done = 1'b1;
      end else if (bvalid) begin
        bready <= 1'b1;
      end
    end
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    logic done;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    done = 1'b0;
    d = '0;
    while (!done) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        d = rdata;
        lr = rresp;
        rready <= 1'b0;
        done = 1'b1;
      end else if (rvalid) begin
        rready <= 1'b1;
      end
    end
  endtask : rd
  task automatic rc(input logic [11:0] a, input logic [31:0] e, input string s);
    logic [31:0] d;
    rd(a, d);
    chk(s, e, d);
  endtask : rc
  task automatic wirq(input int lim);
    n = 0;
    while (irq !== 1'b1 && n < lim) begin
      @(negedge aclk);
      n++;
    end
  endtask : wirq
  // ****************
  // Scenarios
  // ****************
  task automatic t_reset;
    rc(`WDIT_OFS_CTRL, 0, "ctrl");
    rc(`WDIT_OFS_STATUS, 0, "status");
    chk("prio", 0, prio);
    rc(12'h01c, 0, "unmapped");
    chk("rresp", 2, lr);
    wr(12'h01c, 1);
    chk("bresp", 2, lb);
    $display("reset test done");
  endtask : t_reset
  task automatic t_irq;
    wr(`WDIT_OFS_PRIO, 32'h0000_000a);
    chk("bresp ok", 0, lb);
    chk("prio", 32'h0000_000a, prio);
    wr(`WDIT_OFS_IRQ_EN, 1);
    wr(`WDIT_OFS_CTRL, 2);
    wr(`WDIT_OFS_COUNT, 32'h0000_00fa);
    rc(`WDIT_OFS_COUNT, 32'h0000_00fa, "load");
    chk("rresp ok", 0, lr);
    wr(`WDIT_OFS_CMD, 1);
    wirq(30);
    chk("wrap wait", 1, n >= 4 && n <= 6);
    wr(`WDIT_OFS_CMD, 2);
    rc(`WDIT_OFS_STATUS, 1, "itv flag");
    wr(`WDIT_OFS_IRQ_EN, 0);
    chk("masked", 0, irq);
    wr(`WDIT_OFS_IRQ_EN, 1);
    chk("held", 1, irq);
    wr(`WDIT_OFS_CLEAR, 1);
    chk("cleared", 0, irq);
    rc(`WDIT_OFS_STATUS, 0, "flag off");
    $display("interrupt test done");
  endtask : t_irq
  task automatic t_div;
    int dv[8] = '{1, 64, 128, 256, 512, 1024, 4096, 16384};
    for (int s = 0; s < 8; s++) begin
      wr(`WDIT_OFS_CTRL, 32'(s * 16 + 2));
      wr(`WDIT_OFS_COUNT, 32'h0000_00ff);
      wr(`WDIT_OFS_CMD, 1);
      wirq(dv[s] + 40);
      chk("tick span", 1, n >= dv[s] - 2 && n <= dv[s] + 1);
      wr(`WDIT_OFS_CMD, 2);
      wr(`WDIT_OFS_CLEAR, 3);
    end
    $display("prescaler test done");
  endtask : t_div
  task automatic t_wdog;
    int c[3] = '{3, 7, 15};
    int ep[3] = '{0, 4, 0};
    int em[3] = '{0, 0, 4};
    wr(`WDIT_OFS_IRQ_EN, 3);
    for (int i = 0; i < 3; i++) begin
      wr(`WDIT_OFS_CTRL, c[i]);
      wr(`WDIT_OFS_COUNT, 32'h0000_00ff);
      pc = 0;
      mc = 0;
      wr(`WDIT_OFS_CMD, 1);
      wirq(20);
      repeat (8) @(negedge aclk);
      chk("por width", ep[i], pc);
      chk("man width", em[i], mc);
      wr(`WDIT_OFS_CMD, 2);
      rc(`WDIT_OFS_STATUS, 2, "wdt flag");
      wr(`WDIT_OFS_CLEAR, 3);
    end
    $display("watchdog test done");
  endtask : t_wdog
  task automatic t_stop;
    logic [31:0] d;
    wr(`WDIT_OFS_CTRL, 2);
    wr(`WDIT_OFS_COUNT, 32'h0000_0010);
    wr(`WDIT_OFS_CMD, 1);
    wr(`WDIT_OFS_CMD, 2);
    rd(`WDIT_OFS_COUNT, d);
    rc(`WDIT_OFS_COUNT, d, "stopped");
    wr(`WDIT_OFS_CMD, 4);
    rc(`WDIT_OFS_COUNT, 0, "zeroed");
    wr(`WDIT_OFS_COUNT, 32'h0000_00f0);
    wr(`WDIT_OFS_CMD, 1);
    wr(`WDIT_OFS_CTRL, 0);
    wirq(40);
    chk("off irq", 0, irq);
    rc(`WDIT_OFS_STATUS, 0, "off");
    wr(`WDIT_OFS_CMD, 1);
    rc(`WDIT_OFS_STATUS, 0, "no start");
    $display("stop test done");
  endtask : t_stop
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test
  // Longest prescaler case alone is 16384 cycles; the ceiling leaves ample margin
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      errors++;
      stop_test();
    end
  end
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_irq();
    t_div();
    t_wdog();
    t_stop();
    stop_test();
  end
endmodule : tb_top
